// [hw/epiw_pkg.sv]
// constants for the extra external pin interrupt and wake block
// assumes a 200 MHz mclk and an Avalon-MM register port
package epiw_pkg;
  localparam int unsigned NPINS = 8;
  localparam int unsigned AW = 8;
  localparam logic [7:0] ADDR_ENABLE = 8'h84;
  localparam logic [7:0] ADDR_FLAGS = 8'h85;
  localparam logic [7:0] ADDR_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MASK = 8'h89;
  localparam logic [7:0] ADDR_STATUS = 8'h8a;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam int unsigned CTRL_SHARED_BIT = 0;
  localparam int unsigned CTRL_GLOBAL_BIT = 1;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  typedef enum logic [1:0] {EPIW_IDLE, EPIW_ANSWER} epiw_bus_t;
endpackage : epiw_pkg

// [hw/epiw_flag_bit.sv]
// one sticky flag: hardware set, software clear by write of a given value
// assumes synchronous inputs on mclk
`timescale 1ns/10ps
module epiw_flag_bit (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_q
);
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (clr_i) begin
      flag_q <= 1'b0;
    end
  end

  a_set_wins: assert property (@(posedge mclk) disable iff (!rstn)
    set_i |=> flag_q) else $error("flag lost on set");
endmodule : epiw_flag_bit

// [hw/epiw_top.sv]
// extra external pin interrupt enables, flags, wake and irq status
// assumes pin_event pulses are synchronous one-cycle trigger events
`timescale 1ns/10ps
module epiw_top #(
  parameter int unsigned NPINS = epiw_pkg::NPINS
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NPINS-1:0] pin_event,
  input wire logic stop_halt_mode,
  output logic [NPINS-1:0] pin_irq_req,
  output logic wake_req,
  output logic cpu_irq,
  output logic irq
);
  logic [7:0] enable_q;
  logic [NPINS-1:0] flags_q;
  logic [NPINS-1:0] sts_q;
  logic [7:0] mask_q;
  logic shared_en_q;
  logic global_en_q;
  epiw_pkg::epiw_bus_t bus_q;
  logic acc;
  logic wr_go;
  logic lane0;
  logic [NPINS-1:0] armed;
  logic flag_wr;
  logic sts_wr;
  logic [NPINS-1:0] pin_set;
  logic [NPINS-1:0] armed_flags;

  // one wait cycle, answer on second edge
  assign acc = avs_read | avs_write;
  assign avs_waitrequest = acc && (bus_q == epiw_pkg::EPIW_IDLE);
  assign wr_go = avs_write && (bus_q == epiw_pkg::EPIW_ANSWER);
  assign lane0 = avs_byteenable[0];
  assign flag_wr = wr_go && lane0 && (avs_address == epiw_pkg::ADDR_FLAGS);
  assign sts_wr = wr_go && lane0 && (avs_address == epiw_pkg::ADDR_STATUS);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bus_q <= epiw_pkg::EPIW_IDLE;
    end else begin
      case (bus_q)
        epiw_pkg::EPIW_IDLE: begin
          if (acc) begin
            bus_q <= epiw_pkg::EPIW_ANSWER;
          end else begin
            bus_q <= epiw_pkg::EPIW_IDLE;
          end
        end
        epiw_pkg::EPIW_ANSWER: bus_q <= epiw_pkg::EPIW_IDLE;
        default: bus_q <= epiw_pkg::EPIW_IDLE;
      endcase
    end
  end

  // pin enables
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      enable_q <= epiw_pkg::RST_ENABLE;
    end else if (wr_go && lane0 && avs_address == epiw_pkg::ADDR_ENABLE) begin
      enable_q <= avs_writedata[7:0];
    end
  end

  // interrupt mask
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mask_q <= epiw_pkg::RST_MASK;
    end else if (wr_go && lane0 && avs_address == epiw_pkg::ADDR_MASK) begin
      mask_q <= avs_writedata[7:0];
    end
  end

  // shared and global enables
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      shared_en_q <= 1'b0;
      global_en_q <= 1'b0;
    end else if (wr_go && lane0 && avs_address == epiw_pkg::ADDR_CTRL) begin
      shared_en_q <= avs_writedata[epiw_pkg::CTRL_SHARED_BIT];
      global_en_q <= avs_writedata[epiw_pkg::CTRL_GLOBAL_BIT];
    end
  end

  // pin enable and shared enable both needed
  assign armed = enable_q[NPINS-1:0] & {NPINS{shared_en_q}};
  assign pin_set = pin_event & armed;
  assign armed_flags = flags_q & armed;

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      epiw_flag_bit u_flag (
        .mclk(mclk),
        .rstn(rstn),
        .set_i(pin_set[g]),
        .clr_i(flag_wr && !avs_writedata[g]),
        .flag_q(flags_q[g])
      );
      epiw_flag_bit u_sts (
        .mclk(mclk),
        .rstn(rstn),
        .set_i(pin_set[g]),
        .clr_i(sts_wr && avs_writedata[g]),
        .flag_q(sts_q[g])
      );
      // per-pin gating checks
      a_pin_gate: assert property (@(posedge mclk) disable iff (!rstn)
        pin_irq_req[g] |-> $past(enable_q[g]) && $past(shared_en_q))
        else $error("pin request while gated off");
      a_no_stray_set: assert property (@(posedge mclk) disable iff (!rstn)
        (!armed[g] && !flags_q[g]) |=> !flags_q[g])
        else $error("flag set while disarmed");
    end
  endgenerate

  // per-pin requests
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pin_irq_req <= '0;
    end else begin
      pin_irq_req <= armed_flags;
    end
  end

  // wake ignores global enable
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= stop_halt_mode && |armed_flags;
    end
  end

  // cpu irq honours global enable
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cpu_irq <= 1'b0;
    end else begin
      cpu_irq <= global_en_q && |armed_flags;
    end
  end

  // masked sticky status interrupt
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(sts_q & mask_q[NPINS-1:0]);
    end
  end

  // read data
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      avs_readdata <= epiw_pkg::UNMAPPED_DATA;
    end else if (avs_read && bus_q == epiw_pkg::EPIW_IDLE) begin
      case (avs_address)
        epiw_pkg::ADDR_ENABLE: avs_readdata <= {24'h000000, enable_q};
        epiw_pkg::ADDR_FLAGS: avs_readdata <= {24'h000000, flags_q};
        epiw_pkg::ADDR_MASK: avs_readdata <= {24'h000000, mask_q};
        epiw_pkg::ADDR_STATUS: avs_readdata <= {24'h000000, sts_q};
        epiw_pkg::ADDR_CTRL: avs_readdata <= {30'h0, global_en_q, shared_en_q};
        default: avs_readdata <= epiw_pkg::UNMAPPED_DATA;
      endcase
    end
  end

  // gating, flag and bus checks
  a_wake_no_ea: assert property (@(posedge mclk) disable iff (!rstn)
    (stop_halt_mode && |armed_flags && !global_en_q) |=> wake_req)
    else $error("wake blocked by global enable");
  a_shared_gate: assert property (@(posedge mclk) disable iff (!rstn)
    (!shared_en_q && !$past(shared_en_q)) |-> (!wake_req && pin_irq_req == '0))
    else $error("irq without shared enable");
  a_en_gate: assert property (@(posedge mclk) disable iff (!rstn)
    (enable_q == '0 && $past(enable_q) == '0) |-> !wake_req)
    else $error("wake with pins disabled");
  a_flag_clear: assert property (@(posedge mclk) disable iff (!rstn)
    (flag_wr && !avs_writedata[0] && !pin_set[0]) |=> !flags_q[0])
    else $error("flag not cleared");
  a_flag_set: assert property (@(posedge mclk) disable iff (!rstn)
    pin_set[0] |=> flags_q[0] ##1 (pin_irq_req[0] || !$past(armed[0])))
    else $error("pin event lost");
  a_flag_keep: assert property (@(posedge mclk) disable iff (!rstn)
    (flag_wr && avs_writedata[0] && flags_q[0]) |=> flags_q[0])
    else $error("flag cleared by write of one");
  a_status_clear: assert property (@(posedge mclk) disable iff (!rstn)
    (sts_wr && avs_writedata[0] && !pin_set[0]) |=> !sts_q[0])
    else $error("status not cleared");
  a_bus_wait: assert property (@(posedge mclk) disable iff (!rstn)
    ($rose(avs_read) && bus_q == epiw_pkg::EPIW_IDLE) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer timing");
  a_wait_idle: assert property (@(posedge mclk) disable iff (!rstn)
    (!avs_read && !avs_write) |-> !avs_waitrequest)
    else $error("waitrequest while idle");
  a_read_upper: assert property (@(posedge mclk) disable iff (!rstn)
    (avs_read && !avs_waitrequest) |-> avs_readdata[31:8] == '0)
    else $error("read data upper bits set");
  a_read_hold: assert property (@(posedge mclk) disable iff (!rstn)
    !avs_read |=> $stable(avs_readdata))
    else $error("read data changed without read");
  a_be_ignored: assert property (@(posedge mclk) disable iff (!rstn)
    (wr_go && !lane0) |=> ($stable(enable_q) && $stable(mask_q)))
    else $error("write without byte lane applied");
  a_cpu_ea: assert property (@(posedge mclk) disable iff (!rstn)
    !global_en_q |=> !cpu_irq)
    else $error("cpu irq with global enable off");
  a_irq_level: assert property (@(posedge mclk) disable iff (!rstn)
    ((sts_q & mask_q[NPINS-1:0]) != '0) |=> irq)
    else $error("unmasked status without irq");

  // main scenarios
  c_wake: cover property (@(posedge mclk) disable iff (!rstn) $rose(wake_req));
  c_irq: cover property (@(posedge mclk) disable iff (!rstn) $rose(irq));
  c_clash: cover property (@(posedge mclk) disable iff (!rstn)
    pin_set[0] && flag_wr && !avs_writedata[0]);
  c_wake_ea_off: cover property (@(posedge mclk) disable iff (!rstn) !global_en_q && $rose(wake_req));
  c_flag_drop: cover property (@(posedge mclk) disable iff (!rstn) $fell(flags_q[0]));
endmodule : epiw_top

// [verification/epiw_pins_model.sv]
// pin side model: one-cycle trigger pulses on the extra pins
// assumes the bench requests a burst on mclk
`timescale 1ns/10ps
module epiw_pins_model (
  input wire logic mclk,
  input wire logic fire,
  input wire logic [7:0] pat,
  output logic [7:0] pin_event
);
  always @(posedge mclk) begin
    pin_event <= fire ? pat : 8'h00;
  end
endmodule : epiw_pins_model

// [verification/epiw_tb.sv]
// self-checking bench for epiw_top
// assumes the pin model is compiled first
`timescale 1ns/10ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module tb;
  logic mclk = 1'h0, rstn = 1'h0, rd = 1'h0, wr = 1'h0, fire = 1'h0, sh = 1'h0, w_r;
  logic wake, cirq, irq;
  logic [7:0] adr = 8'h00, pat = 8'h00, e, p, x, q, ev, req;
  logic [31:0] wd = 32'h0, rdata;
  logic [3:0] be = 4'h1;
  int err_total = 0, cmp_count = 0, seed = 92;
  always #2.5 mclk = ~mclk;
  epiw_pins_model u_pins (.mclk(mclk), .fire(fire), .pat(pat), .pin_event(ev));
  epiw_top u_dut (.mclk(mclk), .rstn(rstn), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(w_r), .pin_event(ev), .stop_halt_mode(sh), .pin_irq_req(req),
    .wake_req(wake), .cpu_irq(cirq), .irq(irq));
  function automatic int xs(input int s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    adr <= a;
    wd <= {24'h0, d};
    rd <= ~w;
    wr <= w;
    @(posedge mclk);
    while (w_r !== 1'h0) begin
      @(posedge mclk);
    end
    q = rdata[7:0];
    rd <= 1'h0;
    wr <= 1'h0;
    repeat (2) @(posedge mclk);
  endtask : bus
  task automatic wrap_up();
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  initial begin
    #20us;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge mclk);
    rstn <= 1'h1;
    @(posedge mclk);
    bus(1'h0, epiw_pkg::ADDR_ENABLE, 8'h00);
    `CHK("enable_rst", 8'h00, q)
    bus(1'h0, epiw_pkg::ADDR_FLAGS, 8'h00);
    `CHK("flags_rst", 8'h00, q)
    be <= 4'h0;
    bus(1'h1, epiw_pkg::ADDR_ENABLE, 8'hff);
    be <= 4'h1;
    bus(1'h0, epiw_pkg::ADDR_ENABLE, 8'h00);
    `CHK("be_off", 8'h00, q)
    bus(1'h0, 8'h90, 8'h00);
    `CHK("unmapped", 8'h00, q)
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      e = (i == 0) ? 8'hff : seed[7:0];
      p = (i == 0) ? 8'hff : seed[15:8];
      x = i[0] ? 8'h00 : (e & p);
      sh <= !i[2];
      bus(1'h1, epiw_pkg::ADDR_CTRL, {6'h0, i[1], ~i[0]});
      bus(1'h1, epiw_pkg::ADDR_ENABLE, e);
      pat <= p;
      fire <= 1'h1;
      @(posedge mclk);
      fire <= 1'h0;
      repeat (4) @(posedge mclk);
      bus(1'h0, epiw_pkg::ADDR_FLAGS, 8'h00);
      `CHK("flags", x, q)
      `CHK("irq_req", x, req)
      `CHK("wake", !i[2] & (|x), wake)
      `CHK("cpu_irq", i[1] & (|x), cirq)
      `CHK("irq_masked", 1'h0, irq)
      bus(1'h1, epiw_pkg::ADDR_MASK, 8'hff);
      `CHK("irq_on", |x, irq)
      bus(1'h1, epiw_pkg::ADDR_STATUS, 8'hff);
      `CHK("irq_clr", 1'h0, irq)
      bus(1'h1, epiw_pkg::ADDR_MASK, 8'h00);
      bus(1'h1, epiw_pkg::ADDR_FLAGS, 8'h0f);
      bus(1'h0, epiw_pkg::ADDR_FLAGS, 8'h00);
      `CHK("flags_part", x & 8'h0f, q)
      bus(1'h1, epiw_pkg::ADDR_FLAGS, 8'h00);
      bus(1'h0, epiw_pkg::ADDR_FLAGS, 8'h00);
      `CHK("flags_clr", 8'h00, q)
    end
    sh <= 1'h1;
    seed = xs(seed);
    bus(1'h1, epiw_pkg::ADDR_CTRL, 8'h03);
    bus(1'h1, epiw_pkg::ADDR_ENABLE, 8'hff);
    pat <= seed[7:0] | 8'h01;
    fire <= 1'h1;
    @(posedge mclk);
    fire <= 1'h0;
    repeat (4) @(posedge mclk);
    `CHK("pre_rst_req", seed[7:0] | 8'h01, req)
    `CHK("pre_rst_cpu", 1'h1, cirq)
    rstn <= 1'h0;
    repeat (2) @(posedge mclk);
    rstn <= 1'h1;
    @(posedge mclk);
    `CHK("rst_wake", 1'h0, wake)
    `CHK("rst_req", 8'h00, req)
    bus(1'h0, epiw_pkg::ADDR_FLAGS, 8'h00);
    `CHK("rst_flags", 8'h00, q)
    bus(1'h0, epiw_pkg::ADDR_CTRL, 8'h00);
    `CHK("rst_ctrl", 8'h00, q)
    wrap_up();
  end
endmodule : tb
